//--- verilog/pin_interrupt_pattern_match.sv
// pin interrupt and pattern match unit with apb register slave
//
// Decided for this implementation: the register offsets and the APB register port.
module pin_interrupt_pattern_match
    import pint_pkg::*;
#(
    parameter int PIN_COUNT = 32
)
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 ce_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [11:0]          paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    input  wire logic [PIN_COUNT-1:0] pins_i,
    output logic      [NUM_IRQ-1:0]   pin_irq_o
);

    localparam int SEL_W = (PIN_COUNT > 1) ? $clog2(PIN_COUNT) : 1;

    if (PIN_COUNT < 2 || PIN_COUNT > 256)
    begin : g_check
        $error("PIN_COUNT must be 2 to 256");
    end

    logic [PIN_COUNT-1:0] sync1_r;
    logic [PIN_COUNT-1:0] sync2_r;
    logic [SEL_W-1:0]     src_sel_r [NUM_IRQ];
    logic [7:0]           sel_lvl;
    logic [7:0]           prev_r;
    logic [7:0]           rise_ev;
    logic [7:0]           fall_ev;
    logic [7:0]           sens_r;
    logic [7:0]           up_en_r;
    logic [7:0]           dn_en_r;
    logic [7:0]           rise_r;
    logic [7:0]           fall_r;
    logic                 mode_r;
    logic [31:0]          src_r;
    logic [31:0]          cfg_r;
    logic [7:0]           req;
    logic [7:0]           w8;
    logic                 wr;
    logic                 setup;
    logic [31:0]          rdata;
    logic                 hit_ofs;

    pattern_if pm ();

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    function automatic logic is_psel(input logic [11:0] a, output logic [2:0] n);
        n = 3'h0;
        is_psel = 1'b0;
        for (int k = 0; k < NUM_IRQ; k++)
        begin
            if (a == OFS_PSEL0 + 12'(k) * OFS_STEP)
            begin
                is_psel = 1'b1;
                n = 3'(k);
            end
        end
    endfunction

    function automatic logic wr_to(input logic [11:0] ofs);
        return wr && paddr_i == ofs;
    endfunction

    assign pready_o = ce_i;
    assign wr       = ce_i & psel_i & penable_i & pwrite_i;
    assign setup    = ce_i & psel_i & ~penable_i;
    assign w8       = pwdata_i[7:0];

    // ------------------------------------------------------------
    // pin synchroniser and per-irq edge detect
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r  <= 8'h00;
        end
        else if (ce_i)
        begin
            sync1_r <= pins_i;
            sync2_r <= sync1_r;
            prev_r  <= sel_lvl;
        end
    end

    for (genvar n = 0; n < NUM_IRQ; n++)
    begin : g_pin
        assign sel_lvl[n] = sync2_r[src_sel_r[n]];
        assign rise_ev[n] = sel_lvl[n] & ~prev_r[n];
        assign fall_ev[n] = ~sel_lvl[n] & prev_r[n];

        always_ff @(posedge clk_sys_i)
        begin
            if (!rst_n_i)
                src_sel_r[n] <= '0;
            else if (wr && paddr_i == OFS_PSEL0 + 12'(n) * OFS_STEP)
                src_sel_r[n] <= pwdata_i[SEL_W-1:0];
        end

        // slice n input picked among the eight selected pins
        logic [2:0] s;
        assign s = src_r[field_lsb(n) +: SRC_W];
        assign pm.lvl[n]  = sel_lvl[s];
        assign pm.rise[n] = rise_ev[s];
        assign pm.fall[n] = fall_ev[s];
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            sens_r <= 8'h00;
            mode_r <= 1'b0;
            src_r  <= RST_SRC;
            cfg_r  <= RST_CFG;
        end
        else
        begin
            if (wr_to(OFS_SENS))
                sens_r <= w8;
            if (wr_to(OFS_MODE))
                mode_r <= pwdata_i[MODE_BIT];
            if (wr_to(OFS_SRC))
                src_r <= {pwdata_i[31:FIELD_LSB], 8'h00};
            if (wr_to(OFS_CFG))
                cfg_r <= {pwdata_i[31:FIELD_LSB], 1'b0, pwdata_i[6:0]};
        end
    end

    assign pm.cfg = cfg_r;
    assign pm.clr = wr_to(OFS_CFG) | wr_to(OFS_SRC);

    // ------------------------------------------------------------
    // enables with set and clear companions
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            up_en_r <= 8'h00;
        else if (wr_to(OFS_UP_SET))
            up_en_r <= up_en_r | w8;
        else if (wr_to(OFS_UP_CLR))
            up_en_r <= up_en_r & ~w8;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            dn_en_r <= 8'h00;
        else if (wr_to(OFS_DN_SET))
            dn_en_r <= dn_en_r | w8;
        else if (wr_to(OFS_DN_CLR))
            dn_en_r <= dn_en_r & ~w8;
    end

    // ------------------------------------------------------------
    // edge latches, a fresh edge wins over a clearing write
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            rise_r <= 8'h00;
            fall_r <= 8'h00;
        end
        else if (ce_i)
        begin
            rise_r <= (rise_r & ~({8{wr_to(OFS_RISE)}} & w8)
                      & ~({8{wr_to(OFS_STATUS)}} & w8 & ~sens_r))
                      | ({8{wr_to(OFS_RISE_SET)}} & w8) | rise_ev;
            fall_r <= (fall_r & ~({8{wr_to(OFS_FALL)}} & w8)
                      & ~({8{wr_to(OFS_STATUS)}} & w8 & ~sens_r))
                      | ({8{wr_to(OFS_FALL_SET)}} & w8) | fall_ev;
        end
    end

    // ------------------------------------------------------------
    // requests and interrupt outputs
    // ------------------------------------------------------------
    always_comb
    begin
        if (mode_r)
            req = pm.match;
        else
            req = (~sens_r & ((rise_r & up_en_r) | (fall_r & dn_en_r)))
                | (sens_r & up_en_r & ~(sel_lvl ^ dn_en_r));
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            pin_irq_o <= RST_IRQ;
        else if (ce_i)
            pin_irq_o <= req;
    end

    pattern_engine u_engine (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .pm        (pm.engine)
    );

    // ------------------------------------------------------------
    // read mux, captured in the setup cycle
    // ------------------------------------------------------------
    always_comb
    begin
        logic [2:0] n;
        n = 3'h0;
        hit_ofs = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr_i)
            OFS_SENS:   rdata[7:0] = sens_r;
            OFS_UP_EN:  rdata[7:0] = up_en_r;
            OFS_DN_EN:  rdata[7:0] = dn_en_r;
            OFS_RISE:   rdata[7:0] = rise_r;
            OFS_FALL:   rdata[7:0] = fall_r;
            OFS_STATUS: rdata[7:0] = pin_irq_o;
            OFS_MODE:   rdata = {pm.match, 23'h0, mode_r};
            OFS_SRC:    rdata = src_r;
            OFS_CFG:    rdata = cfg_r;
            OFS_UP_SET, OFS_UP_CLR, OFS_DN_SET, OFS_DN_CLR, OFS_RISE_SET, OFS_FALL_SET:
                rdata = 32'h0000_0000;
            default:
            begin
                hit_ofs = is_psel(paddr_i, n);
                if (hit_ofs)
                    rdata[SEL_W-1:0] = src_sel_r[n];
            end
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end
        else if (setup)
        begin
            prdata_o  <= rdata;
            pslverr_o <= ~hit_ofs;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_up_set;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr && paddr_i == OFS_UP_SET && pwdata_i[0] |=> up_en_r[0];
    endproperty
    a_up_set: assert property (p_up_set) else $error("enable set failed");

    property p_up_clr;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr && paddr_i == OFS_UP_CLR && pwdata_i[0] |=> !up_en_r[0];
    endproperty
    a_up_clr: assert property (p_up_clr) else $error("enable clear failed");

    property p_dn_clr;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr && paddr_i == OFS_DN_CLR && !pwdata_i[2] |=> dn_en_r[2] == $past(dn_en_r[2]);
    endproperty
    a_dn_clr: assert property (p_dn_clr) else $error("zero bit changed enable");

    property p_level_req;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && !mode_r && sens_r[1] && up_en_r[1] && sel_lvl[1] == dn_en_r[1] |=> pin_irq_o[1];
    endproperty
    a_level_req: assert property (p_level_req) else $error("level request missing");

    property p_pattern_irq;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && mode_r |=> pin_irq_o == $past(pm.match);
    endproperty
    a_pattern_irq: assert property (p_pattern_irq) else $error("term not routed");

    property p_rise_edge;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && !prev_r[4] && sel_lvl[4] |=> rise_r[4];
    endproperty
    a_rise_edge: assert property (p_rise_edge) else $error("rising edge lost");

    property p_status_clr;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr && paddr_i == OFS_STATUS && pwdata_i[4] && !sens_r[4] && !rise_ev[4] && !fall_ev[4]
        |=> !rise_r[4] && !fall_r[4];
    endproperty
    a_status_clr: assert property (p_status_clr) else $error("status write kept edge");

    property p_sync;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i ##1 ce_i |-> sync2_r == $past(sync1_r);
    endproperty
    a_sync: assert property (p_sync) else $error("synchroniser skipped");

endmodule

//--- verilog/pint_pkg.sv
// shared constants and types of the pin interrupt and pattern match unit
package pint_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_IRQ = 8;
    localparam int COND_W  = 3;
    localparam int SRC_W   = 3;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_SENS     = 12'h000;
    localparam logic [11:0] OFS_UP_EN    = 12'h004;
    localparam logic [11:0] OFS_UP_SET   = 12'h008;
    localparam logic [11:0] OFS_UP_CLR   = 12'h00C;
    localparam logic [11:0] OFS_DN_EN    = 12'h010;
    localparam logic [11:0] OFS_DN_SET   = 12'h014;
    localparam logic [11:0] OFS_DN_CLR   = 12'h018;
    localparam logic [11:0] OFS_RISE     = 12'h01C;
    localparam logic [11:0] OFS_RISE_SET = 12'h020;
    localparam logic [11:0] OFS_FALL     = 12'h024;
    localparam logic [11:0] OFS_FALL_SET = 12'h028;
    localparam logic [11:0] OFS_STATUS   = 12'h02C;
    localparam logic [11:0] OFS_MODE     = 12'h030;
    localparam logic [11:0] OFS_SRC      = 12'h034;
    localparam logic [11:0] OFS_CFG      = 12'h038;
    localparam logic [11:0] OFS_PSEL0    = 12'h040;
    localparam logic [11:0] OFS_STEP     = 12'h004;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int FIELD_LSB   = 8;
    localparam int MODE_BIT    = 0;
    localparam int MATCH_LSB   = 24;
    localparam int TOP_LSB     = 29;
    localparam logic [31:0] RST_CFG = 32'h0000_0000;
    localparam logic [31:0] RST_SRC = 32'h0000_0000;
    localparam logic [7:0]  RST_IRQ = 8'h00;

    typedef enum logic [2:0] {
        COND_HIGH   = 3'h0,
        COND_RISE   = 3'h1,
        COND_FALL   = 3'h2,
        COND_EDGE   = 3'h3,
        COND_LVL_HI = 3'h4,
        COND_LVL_LO = 3'h5,
        COND_NEVER  = 3'h6,
        COND_EVENT  = 3'h7
    } cond_t;

    // lsb of the 3-bit field of slice i in source and config words
    function automatic int field_lsb(input int i);
        return FIELD_LSB + COND_W * i;
    endfunction

endpackage

//--- verilog/pattern_if.sv
// signals between the pin front end and the pattern engine
interface pattern_if;
    logic [7:0]  lvl;
    logic [7:0]  rise;
    logic [7:0]  fall;
    logic        clr;
    logic [31:0] cfg;
    logic [7:0]  match;

    modport engine (input lvl, input rise, input fall, input clr, input cfg, output match);
    modport front  (output lvl, output rise, output fall, output clr, output cfg, input match);
endinterface

//--- verilog/pattern_engine.sv
// bit slices and product terms of the pattern match engine
module pattern_engine
    import pint_pkg::*;
(
    input  wire logic  clk_sys_i,
    input  wire logic  rst_n_i,
    input  wire logic  ce_i,
    pattern_if.engine  pm
);

    logic [7:0] rise_seen_r;
    logic [7:0] fall_seen_r;
    logic [7:0] hit;
    logic [7:0] acc;
    logic [7:0] endpt;

    // ------------------------------------------------------------
    // sticky detectors, new edge beats the clearing write
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            rise_seen_r <= 8'h00;
            fall_seen_r <= 8'h00;
        end
        else if (ce_i)
        begin
            rise_seen_r <= (pm.clr ? 8'h00 : rise_seen_r) | pm.rise;
            fall_seen_r <= (pm.clr ? 8'h00 : fall_seen_r) | pm.fall;
        end
    end

    // top slice ends a term without a bit of its own
    assign endpt = {1'b1, pm.cfg[6:0]};

    // ------------------------------------------------------------
    // slice conditions and running product
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_IRQ; i++)
    begin : g_slice
        cond_t cond;
        assign cond = cond_t'(pm.cfg[field_lsb(i) +: COND_W]);
        always_comb
        begin
            case (cond)
                COND_HIGH:   hit[i] = 1'b1;
                COND_RISE:   hit[i] = rise_seen_r[i];
                COND_FALL:   hit[i] = fall_seen_r[i];
                COND_EDGE:   hit[i] = rise_seen_r[i] | fall_seen_r[i];
                COND_LVL_HI: hit[i] = pm.lvl[i];
                COND_LVL_LO: hit[i] = ~pm.lvl[i];
                COND_NEVER:  hit[i] = 1'b0;
                COND_EVENT:  hit[i] = pm.rise[i] | pm.fall[i];
                default:     hit[i] = 1'b0;
            endcase
        end
        if (i == 0)
        begin : g_first
            assign acc[i] = hit[i];
        end
        else
        begin : g_next
            assign acc[i] = hit[i] & (endpt[i-1] | acc[i-1]);
        end
        assign pm.match[i] = acc[i] & endpt[i];
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_top_never;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        pm.cfg[31:29] == 3'h6 |-> !pm.match[7];
    endproperty
    a_top_never: assert property (p_top_never) else $error("never slice matched");

    property p_top_high;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        pm.cfg[31:29] == 3'h0 && pm.cfg[6] |-> pm.match[7];
    endproperty
    a_top_high: assert property (p_top_high) else $error("constant slice missed");

    property p_sticky_hold;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && rise_seen_r[7] && !pm.clr ##1 !pm.clr [*3] |-> rise_seen_r[7];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("sticky edge lost");

    property p_top_event;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        pm.cfg[31:29] == 3'h7 && pm.cfg[6] |-> pm.match[7] == (pm.rise[7] || pm.fall[7]);
    endproperty
    a_top_event: assert property (p_top_event) else $error("event slice wrong");

    property p_top_level;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        pm.cfg[31:30] == 2'b10 && pm.cfg[6] |-> pm.match[7] == (pm.lvl[7] ^ pm.cfg[29]);
    endproperty
    a_top_level: assert property (p_top_level) else $error("level slice wrong");

endmodule

//--- testbench/pin_interrupt_pattern_match_test.sv
// self-checking bench of the pin interrupt and pattern match unit
module pin_interrupt_pattern_match_test
    import pint_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic               clk_sys;
    logic               rst_n;
    logic               ce;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [11:0]        paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [7:0]         pins;
    logic [NUM_IRQ-1:0] pin_irq;
    logic [32:0]        exp_q[$];
    logic [31:0]        seed;
    int                 n_mismatch;
    int                 total_checks;
    int                 cycles;
    int                 cnt;

    pin_interrupt_pattern_match #(.PIN_COUNT(8)) i_dut (
        .clk_sys_i (clk_sys),
        .rst_n_i   (rst_n),
        .ce_i      (ce),
        .psel_i    (psel),
        .penable_i (penable),
        .pwrite_i  (pwrite),
        .paddr_i   (paddr),
        .pwdata_i  (pwdata),
        .prdata_o  (prdata),
        .pready_o  (pready),
        .pslverr_o (pslverr),
        .pins_i    (pins),
        .pin_irq_o (pin_irq)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
        total_checks++;
        if (seen !== expv)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, expv, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // notes the expected answer, then reads
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err = 1'b0);
        idle(2);
        exp_q.push_back({err, d});
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // slice 6 never true and ends its own term, so slice 7 stands alone
    task automatic cfg_chk(input logic [2:0] code, input logic [7:0] e);
        wr(OFS_CFG, {code, 3'h6, 19'h0_0000, 7'h40});
        rd(OFS_STATUS, {24'h00_0000, e});
    endtask

    task automatic pin_chk(input logic p, input logic [7:0] e);
        @(posedge clk_sys);
        pins[7] <= p;
        idle(6);
        rd(OFS_STATUS, {24'h00_0000, e});
    endtask

    // cycles with the top interrupt high over a ten cycle window
    task automatic count_top(output int c);
        c = 0;
        repeat (10)
        begin
            @(posedge clk_sys);
            if (pin_irq[7] === 1'b1)
                c++;
        end
    endtask

    // ------------------------------------------------------------
    // clock, monitor and timeout
    // ------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    logic [32:0] e_mon;
    always @(posedge clk_sys)
    begin
        if (psel && penable && !pwrite && pready === 1'b1)
        begin
            e_mon = exp_q.pop_front();
            check("prdata", prdata, e_mon[31:0]);
            check("pslverr", {31'h0, pslverr}, {31'h0, e_mon[32]});
        end
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; pins = 8'h00; seed = 32'hD2219526;
        ce = 1'b1;
        idle(20);
        rst_n <= 1'b1;
        exp_q.delete();
        rd(OFS_CFG, RST_CFG);
        rd(OFS_SRC, RST_SRC);
        rd(OFS_STATUS, 32'h0000_0000);
        rd(OFS_MODE, 32'h8000_0000);
        rd(12'h03C, 32'h0000_0000, 1'b1);
        for (int n = 0; n < 8; n++)
            wr(12'(OFS_PSEL0 + OFS_STEP * n), 32'(7 - n));
        rd(12'(OFS_PSEL0 + OFS_STEP * 3), 32'h0000_0004);
        repeat (4)
        begin
            seed = lfsr(seed);
            wr(OFS_SENS, seed);
            rd(OFS_SENS, {24'h00_0000, seed[7:0]});
        end
        wr(OFS_SENS, 32'h0000_0000);
        wr(OFS_UP_SET, 32'h0000_00FF);
        rd(OFS_UP_EN, 32'h0000_00FF);
        wr(OFS_UP_CLR, 32'h0000_000F);
        rd(OFS_UP_EN, 32'h0000_00F0);
        wr(OFS_DN_SET, 32'h0000_000F);
        wr(OFS_DN_CLR, 32'h0000_0003);
        rd(OFS_DN_EN, 32'h0000_000C);
        // edge pin: bit 4 follows pins[3]
        @(posedge clk_sys) pins <= 8'h08;
        idle(6);
        rd(OFS_RISE, 32'h0000_0010);
        rd(OFS_STATUS, 32'h0000_0010);
        @(posedge clk_sys) pins <= 8'h00;
        idle(6);
        rd(OFS_FALL, 32'h0000_0010);
        wr(OFS_STATUS, 32'h0000_0010);
        rd(OFS_RISE, 32'h0000_0000);
        rd(OFS_FALL, 32'h0000_0000);
        rd(OFS_STATUS, 32'h0000_0000);
        wr(OFS_RISE_SET, 32'h0000_0001);
        wr(OFS_FALL_SET, 32'h0000_0004);
        rd(OFS_RISE, 32'h0000_0001);
        rd(OFS_STATUS, 32'h0000_0004);
        wr(OFS_RISE, 32'h0000_0001);
        wr(OFS_FALL, 32'h0000_0004);
        rd(OFS_STATUS, 32'h0000_0000);
        // level pin: bit 1 follows pins[6]
        wr(OFS_SENS, 32'h0000_0002);
        wr(OFS_UP_SET, 32'h0000_0002);
        rd(OFS_STATUS, 32'h0000_0002);
        wr(OFS_DN_SET, 32'h0000_0002);
        rd(OFS_STATUS, 32'h0000_0000);
        @(posedge clk_sys) pins <= 8'h40;
        idle(6);
        rd(OFS_STATUS, 32'h0000_0002);
        wr(OFS_STATUS, 32'h0000_0002);
        rd(OFS_STATUS, 32'h0000_0002);
        wr(OFS_UP_SET, 32'h0000_0080);
        // pattern mode: one term ending at the top slice on pins[7]
        wr(OFS_MODE, 32'h0000_0001);
        cfg_chk(3'h0, 8'h80);
        rd(OFS_MODE, 32'h8000_0001);
        cfg_chk(3'h4, 8'h00);
        cfg_chk(3'h5, 8'h80);
        cfg_chk(3'h6, 8'h00);
        cfg_chk(3'h1, 8'h00);
        pin_chk(1'b1, 8'h80);
        pin_chk(1'b0, 8'h80);
        cfg_chk(3'h1, 8'h00);
        cfg_chk(3'h2, 8'h00);
        pin_chk(1'b1, 8'h00);
        pin_chk(1'b0, 8'h80);
        cfg_chk(3'h3, 8'h00);
        pin_chk(1'b1, 8'h80);
        wr(OFS_SRC, 32'h0000_0000);
        rd(OFS_STATUS, 32'h0000_0000);
        cfg_chk(3'h4, 8'h80);
        rd(OFS_CFG, 32'h9800_0040);
        cfg_chk(3'h7, 8'h00);
        rd(OFS_CFG, 32'hF800_0040);
        @(posedge clk_sys) pins[7] <= 1'b0;
        count_top(cnt);
        check("event", 32'(cnt), 32'h0000_0001);
        // a low clock enable must hide the next edge until it returns
        @(posedge clk_sys) ce <= 1'b0;
        pins[7] <= 1'b1;
        count_top(cnt);
        check("freeze", 32'(cnt), 32'h0000_0000);
        ce <= 1'b1;
        count_top(cnt);
        check("thaw", 32'(cnt), 32'h0000_0001);
        idle(4);
        final_report();
    end
endmodule
